// *** rtl/cce_pkg.sv ***
// shared constants and types for the call/clear/complement executor
package cce_pkg;

    // ----------------------------------------------------------------
    // operation codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CCE_OP_NOP,
        CCE_OP_CALL,
        CCE_OP_CLEAR_BYTE,
        CCE_OP_CLEAR_BIT,
        CCE_OP_CLEAR_WDT,
        CCE_OP_FIRST_PRECLEAR,
        CCE_OP_SECOND_PRECLEAR,
        CCE_OP_COMPLEMENT
    } cce_op_t;

    // ----------------------------------------------------------------
    // sequencer and pre-clear pairing states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CCE_ST_IDLE,
        CCE_ST_PUSH,
        CCE_ST_JUMP
    } cce_fsm_t;

    typedef enum logic [1:0] {
        CCE_PRE_NONE,
        CCE_PRE_FIRST,
        CCE_PRE_SECOND
    } cce_pre_t;

    // ----------------------------------------------------------------
    // widths, reset values and constants
    // ----------------------------------------------------------------
    localparam int          CCE_PC_W_DEF     = 12;
    localparam int          CCE_ADDR_W_DEF   = 8;
    localparam int          CCE_DATA_W       = 8;
    localparam int          CCE_BIT_SEL_W    = 3;
    localparam logic        CCE_READY_RST    = 1'b1;
    localparam logic        CCE_TIMEOUT_RST  = 1'b0;
    localparam logic        CCE_PWRDOWN_RST  = 1'b0;
    localparam logic [7:0]  CCE_CLEAR_BYTE   = 8'h00;
    localparam int          CCE_PC_STEP      = 1;

endpackage

// *** rtl/cce_exec.sv ***
// execution unit for call, clear, watchdog clear and complement operations
`timescale 1ns/1ps
`default_nettype none

module cce_exec #(
    parameter int PC_W   = cce_pkg::CCE_PC_W_DEF,
    parameter int ADDR_W = cce_pkg::CCE_ADDR_W_DEF
) (
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_op_valid,
    input  wire cce_pkg::cce_op_t              i_opcode,
    input  wire logic [PC_W-1:0]               i_pc,
    input  wire logic [PC_W-1:0]               i_target,
    input  wire logic [ADDR_W-1:0]             i_addr,
    input  wire logic [cce_pkg::CCE_BIT_SEL_W-1:0] i_bit_sel,
    input  wire logic [cce_pkg::CCE_DATA_W-1:0]    i_mem_rdata,
    input  wire logic                          i_timeout_set,
    input  wire logic                          i_power_down_set,
    output logic                               o_ready,
    output logic                               o_done,
    output logic                               o_stack_push,
    output logic [PC_W-1:0]                    o_stack_data,
    output logic                               o_pc_load,
    output logic [PC_W-1:0]                    o_pc_value,
    output logic                               o_mem_we,
    output logic [ADDR_W-1:0]                  o_mem_addr,
    output logic [cce_pkg::CCE_DATA_W-1:0]     o_mem_wdata,
    output logic                               o_zero_we,
    output logic                               o_zero_flag,
    output logic                               o_watchdog_clear,
    output logic                               o_watchdog_timeout_flag,
    output logic                               o_power_down_flag
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        cce_pkg::cce_fsm_t             fsm;
        cce_pkg::cce_pre_t             pre;
        logic [PC_W-1:0]               target;
        logic                          ready;
        logic                          done;
        logic                          stack_push;
        logic [PC_W-1:0]               stack_data;
        logic                          pc_load;
        logic [PC_W-1:0]               pc_value;
        logic                          mem_we;
        logic [ADDR_W-1:0]             mem_addr;
        logic [cce_pkg::CCE_DATA_W-1:0] mem_wdata;
        logic                          zero_we;
        logic                          zero_flag;
        logic                          wdt_clear;
        logic                          timeout_flag;
        logic                          power_down_flag;
    } cce_state_t;

    cce_state_t                     st_r;
    cce_state_t                     st_nxt;
    logic                           accept;
    logic                           flag_clear;
    logic [cce_pkg::CCE_DATA_W-1:0] inverted;

    assign accept   = i_op_valid && st_r.ready;
    assign inverted = ~i_mem_rdata;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt            = st_r;
        flag_clear        = 1'b0;
        // strobes last one cycle
        st_nxt.done       = 1'b0;
        st_nxt.stack_push = 1'b0;
        st_nxt.pc_load    = 1'b0;
        st_nxt.mem_we     = 1'b0;
        st_nxt.zero_we    = 1'b0;
        st_nxt.wdt_clear  = 1'b0;
        case (st_r.fsm)
            cce_pkg::CCE_ST_IDLE: begin
                if (accept) begin
                    st_nxt.mem_addr = i_addr;
                    case (i_opcode)
                        cce_pkg::CCE_OP_CALL: begin
                            st_nxt.stack_push = 1'b1;
                            st_nxt.stack_data = PC_W'(i_pc
                                + PC_W'(cce_pkg::CCE_PC_STEP));
                            st_nxt.target     = i_target;
                            st_nxt.ready      = 1'b0;
                            st_nxt.fsm        = cce_pkg::CCE_ST_PUSH;
                        end
                        cce_pkg::CCE_OP_CLEAR_BYTE: begin
                            st_nxt.mem_we    = 1'b1;
                            st_nxt.mem_wdata = cce_pkg::CCE_CLEAR_BYTE;
                            st_nxt.done      = 1'b1;
                        end
                        cce_pkg::CCE_OP_CLEAR_BIT: begin
                            st_nxt.mem_we    = 1'b1;
                            st_nxt.mem_wdata = i_mem_rdata;
                            st_nxt.mem_wdata[i_bit_sel] = 1'b0;
                            st_nxt.done      = 1'b1;
                        end
                        cce_pkg::CCE_OP_CLEAR_WDT: begin
                            flag_clear  = 1'b1;
                            st_nxt.pre  = cce_pkg::CCE_PRE_NONE;
                            st_nxt.done = 1'b1;
                        end
                        cce_pkg::CCE_OP_FIRST_PRECLEAR: begin
                            flag_clear  = st_r.pre
                                == cce_pkg::CCE_PRE_SECOND;
                            st_nxt.pre  = flag_clear
                                ? cce_pkg::CCE_PRE_NONE
                                : cce_pkg::CCE_PRE_FIRST;
                            st_nxt.done = 1'b1;
                        end
                        cce_pkg::CCE_OP_SECOND_PRECLEAR: begin
                            flag_clear  = st_r.pre
                                == cce_pkg::CCE_PRE_FIRST;
                            st_nxt.pre  = flag_clear
                                ? cce_pkg::CCE_PRE_NONE
                                : cce_pkg::CCE_PRE_SECOND;
                            st_nxt.done = 1'b1;
                        end
                        cce_pkg::CCE_OP_COMPLEMENT: begin
                            st_nxt.mem_we    = 1'b1;
                            st_nxt.mem_wdata = inverted;
                            st_nxt.zero_we   = 1'b1;
                            st_nxt.zero_flag = inverted
                                == cce_pkg::CCE_CLEAR_BYTE;
                            st_nxt.done      = 1'b1;
                        end
                        default: begin
                            st_nxt.done = 1'b1;
                        end
                    endcase
                end
            end
            cce_pkg::CCE_ST_PUSH: begin
                st_nxt.pc_load  = 1'b1;
                st_nxt.pc_value = st_r.target;
                st_nxt.done     = 1'b1;
                st_nxt.ready    = 1'b1;
                st_nxt.fsm      = cce_pkg::CCE_ST_IDLE;
            end
            default: begin
                st_nxt.ready = 1'b1;
                st_nxt.fsm   = cce_pkg::CCE_ST_IDLE;
            end
        endcase
        st_nxt.wdt_clear = flag_clear;
        // a set in the clearing cycle wins so no event is lost
        st_nxt.timeout_flag    = i_timeout_set
            || (st_r.timeout_flag && !flag_clear);
        st_nxt.power_down_flag = i_power_down_set
            || (st_r.power_down_flag && !flag_clear);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_r                 <= '0;
            st_r.ready           <= cce_pkg::CCE_READY_RST;
            st_r.timeout_flag    <= cce_pkg::CCE_TIMEOUT_RST;
            st_r.power_down_flag <= cce_pkg::CCE_PWRDOWN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_ready                 = st_r.ready;
    assign o_done                  = st_r.done;
    assign o_stack_push            = st_r.stack_push;
    assign o_stack_data            = st_r.stack_data;
    assign o_pc_load               = st_r.pc_load;
    assign o_pc_value              = st_r.pc_value;
    assign o_mem_we                = st_r.mem_we;
    assign o_mem_addr              = st_r.mem_addr;
    assign o_mem_wdata             = st_r.mem_wdata;
    assign o_zero_we               = st_r.zero_we;
    assign o_zero_flag             = st_r.zero_flag;
    assign o_watchdog_clear        = st_r.wdt_clear;
    assign o_watchdog_timeout_flag = st_r.timeout_flag;
    assign o_power_down_flag       = st_r.power_down_flag;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    property p_call_push;
        accept && i_opcode == cce_pkg::CCE_OP_CALL |=>
            o_stack_push && !o_pc_load && !o_ready
            && o_stack_data == PC_W'($past(i_pc) + PC_W'(1));
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("call did not push pc plus one");

    property p_call_two_cycles;
        accept && i_opcode == cce_pkg::CCE_OP_CALL |=>
            !o_done ##1 (o_pc_load && o_done && o_ready
            && o_pc_value == $past(i_target, 2));
    endproperty
    a_call_two_cycles: assert property (p_call_two_cycles)
        else $error("call jump not in second cycle");

    property p_clear_byte;
        accept && i_opcode == cce_pkg::CCE_OP_CLEAR_BYTE |=>
            o_mem_we && o_mem_wdata == 8'h00 && !o_zero_we
            && o_mem_addr == $past(i_addr);
    endproperty
    a_clear_byte: assert property (p_clear_byte)
        else $error("byte clear wrong");

    property p_clear_bit;
        accept && i_opcode == cce_pkg::CCE_OP_CLEAR_BIT |=>
            o_mem_we && !o_zero_we && o_mem_wdata
            == ($past(i_mem_rdata) & ~(8'h01 << $past(i_bit_sel)));
    endproperty
    a_clear_bit: assert property (p_clear_bit)
        else $error("bit clear wrong");

    property p_wdt_clear;
        accept && i_opcode == cce_pkg::CCE_OP_CLEAR_WDT
            && !i_timeout_set && !i_power_down_set |=>
            o_watchdog_clear && !o_watchdog_timeout_flag
            && !o_power_down_flag;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear)
        else $error("watchdog clear missed");

    property p_pair_clears;
        accept && i_opcode == cce_pkg::CCE_OP_FIRST_PRECLEAR
            && st_r.pre != cce_pkg::CCE_PRE_SECOND
            ##1 accept && i_opcode == cce_pkg::CCE_OP_SECOND_PRECLEAR
            |=> o_watchdog_clear;
    endproperty
    a_pair_clears: assert property (p_pair_clears)
        else $error("alternating pre-clear pair had no effect");

    property p_repeat_inert;
        accept && i_opcode == cce_pkg::CCE_OP_SECOND_PRECLEAR
            && st_r.pre != cce_pkg::CCE_PRE_FIRST |=>
            !o_watchdog_clear
            && (o_watchdog_timeout_flag || !$past(o_watchdog_timeout_flag));
    endproperty
    a_repeat_inert: assert property (p_repeat_inert)
        else $error("repeated pre-clear took effect");

    property p_complement;
        accept && i_opcode == cce_pkg::CCE_OP_COMPLEMENT |=>
            o_mem_we && o_mem_wdata == ~$past(i_mem_rdata)
            && o_mem_addr == $past(i_addr);
    endproperty
    a_complement: assert property (p_complement)
        else $error("complement result wrong");

    property p_zero_flags;
        accept && i_opcode == cce_pkg::CCE_OP_COMPLEMENT |=>
            o_zero_we && o_zero_flag == ($past(i_mem_rdata) == 8'hff);
    endproperty
    a_zero_flags: assert property (p_zero_flags)
        else $error("complement zero flag wrong");

    property p_call_keeps_flags;
        accept && i_opcode == cce_pkg::CCE_OP_CALL |=>
            (!o_zero_we && !o_watchdog_clear) [*2];
    endproperty
    a_call_keeps_flags: assert property (p_call_keeps_flags)
        else $error("call touched flags");

endmodule

`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the call/clear/complement executor
`timescale 1ns/1ps
`default_nettype none

module tb;
    typedef struct {
        logic        we;  logic [7:0]  ad; logic [7:0] wd;
        logic        zwe; logic        zf; logic       wdc;
        logic        to;  logic        pd; logic       call;
        logic [11:0] stk; logic [11:0] tgt;
    } cce_tb_note_t;

    logic              i_sys_clk = 1'b0;
    logic              i_rst_n = 1'b0;
    logic              i_op_valid = 1'b0;
    cce_pkg::cce_op_t  i_opcode = cce_pkg::CCE_OP_NOP;
    logic [11:0]       i_pc = '0, i_target = '0;
    logic [7:0]        i_addr = '0, i_mem_rdata = '0;
    logic [2:0]        i_bit_sel = '0;
    logic              i_timeout_set = 1'b0, i_power_down_set = 1'b0;
    logic              o_ready, o_done, o_stack_push, o_pc_load, o_mem_we;
    logic              o_zero_we, o_zero_flag, o_watchdog_clear;
    logic              o_watchdog_timeout_flag, o_power_down_flag;
    logic [11:0]       o_stack_data, o_pc_value;
    logic [7:0]        o_mem_addr, o_mem_wdata;
    cce_tb_note_t      notes[$];
    cce_tb_note_t      n;
    cce_pkg::cce_pre_t m_pre = cce_pkg::CCE_PRE_NONE;
    logic              m_to = 1'b0, m_pd = 1'b0, stk_seen = 1'b0;
    logic [11:0]       stk_r = '0;
    int                err_count = 0, samples_checked = 0, seed = 12587, r;
    int                k;
    cce_pkg::cce_op_t  pair_tab[10] = '{cce_pkg::CCE_OP_FIRST_PRECLEAR,
        cce_pkg::CCE_OP_FIRST_PRECLEAR, cce_pkg::CCE_OP_SECOND_PRECLEAR,
        cce_pkg::CCE_OP_SECOND_PRECLEAR, cce_pkg::CCE_OP_SECOND_PRECLEAR,
        cce_pkg::CCE_OP_FIRST_PRECLEAR, cce_pkg::CCE_OP_CLEAR_WDT,
        cce_pkg::CCE_OP_FIRST_PRECLEAR, cce_pkg::CCE_OP_CLEAR_WDT,
        cce_pkg::CCE_OP_SECOND_PRECLEAR};

    cce_exec u_cce_exec (
        .i_sys_clk               (i_sys_clk),
        .i_rst_n                 (i_rst_n),
        .i_op_valid              (i_op_valid),
        .i_opcode                (i_opcode),
        .i_pc                    (i_pc),
        .i_target                (i_target),
        .i_addr                  (i_addr),
        .i_bit_sel               (i_bit_sel),
        .i_mem_rdata             (i_mem_rdata),
        .i_timeout_set           (i_timeout_set),
        .i_power_down_set        (i_power_down_set),
        .o_ready                 (o_ready),
        .o_done                  (o_done),
        .o_stack_push            (o_stack_push),
        .o_stack_data            (o_stack_data),
        .o_pc_load               (o_pc_load),
        .o_pc_value              (o_pc_value),
        .o_mem_we                (o_mem_we),
        .o_mem_addr              (o_mem_addr),
        .o_mem_wdata             (o_mem_wdata),
        .o_zero_we               (o_zero_we),
        .o_zero_flag             (o_zero_flag),
        .o_watchdog_clear        (o_watchdog_clear),
        .o_watchdog_timeout_flag (o_watchdog_timeout_flag),
        .o_power_down_flag       (o_power_down_flag)
    );

    always #5 i_sys_clk = ~i_sys_clk;

    task automatic close_out;
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // ----------------------------------------------------------------
    // driver: one request per do_op, none from idle, expectation noted on issue
    // ----------------------------------------------------------------
    task automatic idle(input logic ts, input logic pds);
        @(negedge i_sys_clk);
        // a call in flight ends before a flag event, else its note is stale
        while (o_ready !== 1'b1)
            @(negedge i_sys_clk);
        i_op_valid = 1'b0;
        i_timeout_set = ts;
        i_power_down_set = pds;
        m_to = m_to | ts;
        m_pd = m_pd | pds;
    endtask

    task automatic do_op(input cce_pkg::cce_op_t op, input logic [11:0] pc,
                         input logic [11:0] tg, input logic [7:0] ad,
                         input logic [7:0] rd, input logic [2:0] bs);
        cce_tb_note_t e;
        logic         clr;
        e = '{default: '0};
        clr = 1'b0;
        e.ad = ad;
        case (op)
            cce_pkg::CCE_OP_CALL: begin
                e.call = 1'b1;
                e.stk = pc + 12'h001;
                e.tgt = tg;
            end
            cce_pkg::CCE_OP_CLEAR_BYTE: e.we = 1'b1;
            cce_pkg::CCE_OP_CLEAR_BIT: begin
                e.we = 1'b1;
                e.wd = rd & ~(8'h01 << bs);
            end
            cce_pkg::CCE_OP_COMPLEMENT: begin
                e.we = 1'b1;
                e.wd = ~rd;
                e.zwe = 1'b1;
                e.zf = (~rd == 8'h00);
            end
            cce_pkg::CCE_OP_CLEAR_WDT: clr = 1'b1;
            cce_pkg::CCE_OP_FIRST_PRECLEAR: begin
                clr = (m_pre == cce_pkg::CCE_PRE_SECOND);
                m_pre = clr ? cce_pkg::CCE_PRE_NONE : cce_pkg::CCE_PRE_FIRST;
            end
            cce_pkg::CCE_OP_SECOND_PRECLEAR: begin
                clr = (m_pre == cce_pkg::CCE_PRE_FIRST);
                m_pre = clr ? cce_pkg::CCE_PRE_NONE : cce_pkg::CCE_PRE_SECOND;
            end
            default: ;
        endcase
        if (op == cce_pkg::CCE_OP_CLEAR_WDT)
            m_pre = cce_pkg::CCE_PRE_NONE;
        if (clr) begin
            m_to = 1'b0;
            m_pd = 1'b0;
        end
        e.wdc = clr;
        e.to = m_to;
        e.pd = m_pd;
        @(negedge i_sys_clk);
        i_op_valid = 1'b1;
        i_opcode = op;
        i_pc = pc;
        i_target = tg;
        i_addr = ad;
        i_mem_rdata = rd;
        i_bit_sel = bs;
        i_timeout_set = 1'b0;
        i_power_down_set = 1'b0;
        notes.push_back(e);
        // held while refused during the second cycle of a call
        while (o_ready !== 1'b1)
            @(negedge i_sys_clk);
    endtask

    // ----------------------------------------------------------------
    // monitor: sampled mid-cycle, where registered outputs are settled
    // ----------------------------------------------------------------
    always @(negedge i_sys_clk) begin
        if (i_rst_n === 1'b1) begin
            if (o_stack_push === 1'b1) begin
                stk_r = o_stack_data;
                stk_seen = 1'b1;
                chk(o_ready === 1'b0 && o_done !== 1'b1, "call busy");
            end
            if (o_done !== 1'b1) begin
                chk(o_mem_we !== 1'b1 && o_pc_load !== 1'b1
                    && o_watchdog_clear !== 1'b1 && o_zero_we !== 1'b1,
                    "stray strobe");
            end else if (notes.size() == 0) begin
                chk(1'b0, "done without request");
            end else begin
                n = notes.pop_front();
                chk(o_mem_we === n.we && (n.we !== 1'b1 || (o_mem_addr === n.ad
                    && o_mem_wdata === n.wd)), "memory write");
                chk(o_zero_we === n.zwe && (n.zwe !== 1'b1
                    || o_zero_flag === n.zf), "zero flag");
                chk(o_watchdog_clear === n.wdc, "counter clear");
                chk(o_watchdog_timeout_flag === n.to
                    && o_power_down_flag === n.pd, "flags");
                chk(o_pc_load === n.call && (n.call === 1'b1 ? (stk_seen === 1'b1
                    && stk_r === n.stk && o_pc_value === n.tgt)
                    : stk_seen !== 1'b1), "call");
                stk_seen = 1'b0;
            end
        end
    end

    initial begin
        #100000;
        err_count++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        chk(o_ready === 1'b1 && o_done === 1'b0 && o_mem_we === 1'b0
            && o_watchdog_timeout_flag === 1'b0
            && o_power_down_flag === 1'b0, "reset values");
        idle(1'b1, 1'b1);
        do_op(cce_pkg::CCE_OP_CLEAR_BYTE, '0, '0, 8'hff, 8'hff, 3'h0);
        for (k = 0; k < 8; k++)
            do_op(cce_pkg::CCE_OP_CLEAR_BIT, '0, '0, 8'(k), 8'hff, 3'(k));
        do_op(cce_pkg::CCE_OP_COMPLEMENT, '0, '0, 8'h5a, 8'hff, 3'h0);
        do_op(cce_pkg::CCE_OP_COMPLEMENT, '0, '0, 8'h00, 8'h00, 3'h0);
        do_op(cce_pkg::CCE_OP_CALL, 12'hfff, 12'h123, 8'h00, 8'h00, 3'h0);
        do_op(cce_pkg::CCE_OP_CLEAR_BYTE, '0, '0, 8'h3c, 8'h77, 3'h0);
        do_op(cce_pkg::CCE_OP_NOP, '0, '0, 8'h00, 8'h00, 3'h0);
        // ------------------------------------------------------------
        // pairing table, flags raised again before each step
        // ------------------------------------------------------------
        for (k = 0; k < 10; k++) begin
            idle(1'b1, 1'b1);
            do_op(pair_tab[k], '0, '0, 8'h00, 8'h00, 3'h0);
        end
        // same table back to back, so pairs fall on adjacent cycles
        idle(1'b1, 1'b1);
        for (k = 0; k < 10; k++)
            do_op(pair_tab[k], '0, '0, 8'h00, 8'h00, 3'h0);
        // pre-clears kept out: other ops may disturb the pairing
        for (k = 0; k < 200; k++) begin
            r = $random(seed);
            if (r[10:8] == 3'h5 || r[10:8] == 3'h6)
                r[10:8] = 3'h0;
            do_op(cce_pkg::cce_op_t'(r[10:8]), 12'(r), 12'($random(seed)),
                  8'(r >> 12), r[27:25] == 3'h0 ? 8'hff : 8'(r >> 20),
                  r[30:28]);
            if (r[31])
                idle(r[11], r[24]);
        end
        idle(1'b0, 1'b0);
        repeat (4) @(negedge i_sys_clk);
        chk(notes.size() == 0, "missing completions");
        close_out();
    end
endmodule

`default_nettype wire
